// ### interrupt_enable_flag_control.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module interrupt_enable_flag_control
  import irq_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [ADDR_W-1:0]    paddr_in,
  input  wire logic [DATA_W-1:0]    pwdata_in,
  output logic      [DATA_W-1:0]    prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  input  wire logic                 timer_overflow_in,
  input  wire logic                 ext_irq_pin_in,
  input  wire logic [PORT_PINS-1:0] upper_port_pins_in,
  output logic                      irq_req_out,
  output logic      [RATE_W:0]      timer_div_log2_out,
  output logic      [RATE_W-1:0]    wdt_div_log2_out
);
  pin_event_if evt ();

  pin_event_detect #(
    .PINS (PORT_PINS)
  ) u_pins (
    .clk_in             (clk_in),
    .rst_in             (rst_in),
    .ext_irq_pin_in     (ext_irq_pin_in),
    .upper_port_pins_in (upper_port_pins_in),
    .evt                (evt)
  );

  logic [REG_W-1:0]  ctrl_r,    ctrl_nxt;
  logic [REG_W-1:0]  option_r,  option_nxt;
  apb_state_t        state_r,   state_nxt;
  logic [DATA_W-1:0] rdata_r,   rdata_nxt;
  logic              ready_r,   ready_nxt;
  logic              err_r,     err_nxt;
  logic              irq_r,     irq_nxt;

  prescale_decode u_presc (
    .clk_in             (clk_in),
    .rst_in             (rst_in),
    .rate_in            (option_r[RATE_LSB +: RATE_W]),
    .assign_wdt_in      (option_r[BIT_PSA]),
    .timer_div_log2_out (timer_div_log2_out),
    .wdt_div_log2_out   (wdt_div_log2_out)
  );

  function automatic logic is_ctrl(input logic [ADDR_W-1:0] a);
    is_ctrl = (a == byte_addr(IDX_CTRL_BANK0)) ||
              (a == byte_addr(IDX_CTRL_BANK1));
  endfunction

  function automatic logic is_option(input logic [ADDR_W-1:0] a);
    is_option = (a == byte_addr(IDX_OPTION));
  endfunction

  logic wr_ctrl;
  logic wr_option;
  logic ext_evt;
  always_comb begin
    wr_ctrl   = (state_r == APB_ACCESS) && psel_in && penable_in &&
                pwrite_in && is_ctrl(paddr_in);
    wr_option = (state_r == APB_ACCESS) && psel_in && penable_in &&
                pwrite_in && is_option(paddr_in);
    ext_evt   = option_r[BIT_EDGE_SEL] ? evt.ext_rise
                                       : evt.ext_fall;
  end

  // register contents: events are or-ed in after the write so a set
  // arriving with a software clear is kept
  always_comb begin
    ctrl_nxt   = ctrl_r;
    option_nxt = option_r;
    if (wr_ctrl) begin
      ctrl_nxt = pwdata_in[REG_W-1:0];
    end
    ctrl_nxt[BIT_RSVD] = 1'b0;
    if (wr_option) begin
      option_nxt = pwdata_in[REG_W-1:0];
    end
    if (timer_overflow_in) begin
      ctrl_nxt[BIT_TMR_IF] = 1'b1;
    end
    if (ext_evt) begin
      ctrl_nxt[BIT_EXT_IF] = 1'b1;
    end
    if (evt.port_change) begin
      ctrl_nxt[BIT_PORT_IF] = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r   <= CTRL_RESET;
      option_r <= OPTION_RESET;
    end else begin
      ctrl_r   <= ctrl_nxt;
      option_r <= option_nxt;
    end
  end

  // request follows the register by one cycle so the output is a flop
  always_comb begin
    irq_nxt = ctrl_r[BIT_GIE] &
              ((ctrl_r[BIT_TMR_IF]  & ctrl_r[BIT_TMR_IE])  |
               (ctrl_r[BIT_EXT_IF]  & ctrl_r[BIT_EXT_IE])  |
               (ctrl_r[BIT_PORT_IF] & ctrl_r[BIT_PORT_IE]));
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // apb slave: no wait states; read data sampled in the setup cycle
  always_comb begin
    state_nxt = state_r;
    rdata_nxt = rdata_r;
    ready_nxt = 1'b0;
    err_nxt   = 1'b0;
    unique case (state_r)
      APB_IDLE: begin
        if (psel_in && !penable_in) begin
          state_nxt = APB_ACCESS;
          ready_nxt = 1'b1;
          err_nxt   = !(is_ctrl(paddr_in) || is_option(paddr_in));
          rdata_nxt = '0;
          if (!pwrite_in && is_ctrl(paddr_in)) begin
            rdata_nxt[REG_W-1:0] = ctrl_r;
          end else if (!pwrite_in && is_option(paddr_in)) begin
            rdata_nxt[REG_W-1:0] = option_r;
          end
        end
      end
      APB_ACCESS: begin
        state_nxt = APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= APB_IDLE;
      rdata_r <= '0;
      ready_r <= 1'b0;
      err_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      err_r   <= err_nxt;
    end
  end

  assign prdata_out  = rdata_r;
  assign pready_out  = ready_r;
  assign pslverr_out = err_r;
  assign irq_req_out = irq_r;
endmodule
`default_nettype wire

// ### interrupt_enable_flag_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module interrupt_enable_flag_control_tb;
  import irq_pkg::*;
  logic        clk_in, rst_in, psel_in, penable_in, pwrite_in, pready_out;
  logic        pslverr_out, timer_overflow_in, ext_irq_pin_in, irq_req_out;
  logic        ovf, pin, errq;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rdq;
  logic [3:0]  upper_port_pins_in, port, timer_div_log2_out;
  logic [2:0]  wdt_div_log2_out;
  int          mismatches, checked, seed, m_ctrl, m_opt, i;
  interrupt_enable_flag_control i_interrupt_enable_flag_control (.clk_in,
    .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .timer_overflow_in,
    .ext_irq_pin_in, .upper_port_pins_in, .irq_req_out, .timer_div_log2_out,
    .wdt_div_log2_out);
  irq_src_model i_irq_src_model (.clk_in, .ovf_req_in(ovf), .pin_req_in(pin),
    .port_req_in(port), .ovf_out(timer_overflow_in), .pin_out(ext_irq_pin_in),
    .port_out(upper_port_pins_in));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic report_and_stop();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h00_0000, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    // no local limit: a slave that never answers is ended by the watchdog
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    rdq = prdata_out;
    errq = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
    if (a == 12'h204)
      m_opt = d;
    else if (a[7:0] == 8'h2c)
      m_ctrl = d & 8'hbf;
  endtask
  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 8'h00);
    chk(rdq, a == 12'h204 ? m_opt : m_ctrl);
  endtask
  task automatic rate_chk();
    repeat (3) @(posedge clk_in);
    chk(timer_div_log2_out, m_opt[3] ? 0 : (m_opt & 7) + 1);
    chk(wdt_div_log2_out, m_opt[3] ? m_opt & 7 : 0);
  endtask
  task automatic pin_step(input logic [7:0] c, input logic l, input int f);
    wr(12'h02c, c);
    pin <= l;
    repeat (8) @(posedge clk_in);
    m_ctrl = m_ctrl | f;
    rd(12'h22c);
  endtask
  initial begin
    repeat (5000) @(posedge clk_in);
    mismatches++;
    report_and_stop();
  end
  initial begin
    {psel_in, penable_in, pwrite_in, ovf, pin} = 5'h00;
    {paddr_in, pwdata_in, port} = '0;
    {mismatches, checked, seed, m_ctrl, m_opt} = {64'd0, 32'd15716, 32'd0, 32'hff};
    rst_in = 1'b1;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(12'h02c);
    rd(12'h204);
    i = $random(seed);
    wr(12'h22c, 8'(i) & 8'hbf);
    rd(12'h02c);
    wr(12'h02c, 8'h00);
    ovf <= 1'b1;
    @(posedge clk_in);
    ovf <= 1'b0;
    m_ctrl = 4;
    repeat (4) @(posedge clk_in);
    chk(irq_req_out, 0);
    rd(12'h22c);
    wr(12'h02c, 8'ha4);
    repeat (2) @(posedge clk_in);
    chk(irq_req_out, 1);
    wr(12'h02c, 8'h24);
    repeat (2) @(posedge clk_in);
    chk(irq_req_out, 0);
    rd(12'h02c);
    wr(12'h02c, 8'h87);
    repeat (2) @(posedge clk_in);
    chk(irq_req_out, 0);
    wr(12'h02c, 8'ha0);
    ovf <= 1'b1;
    @(posedge clk_in);
    ovf <= 1'b0;
    m_ctrl = 8'ha4;
    repeat (4) @(posedge clk_in);
    chk(irq_req_out, 1);
    rd(12'h02c);
    wr(12'h204, 8'h40);
    pin_step(8'h90, 1'b1, 2);
    chk(irq_req_out, 1);
    wr(12'h204, 8'h00);
    pin_step(8'h10, 1'b0, 2);
    pin_step(8'h10, 1'b1, 0);
    wr(12'h02c, 8'h88);
    port <= 4'($random(seed)) | 4'h1;
    repeat (8) @(posedge clk_in);
    m_ctrl = m_ctrl | 1;
    chk(irq_req_out, 1);
    rd(12'h02c);
    xfer(1'b0, 12'h100, 8'h00);
    chk(32'(errq), 1);
    chk(rdq, 0);
    for (i = 0; i < 16; i++) begin
      wr(12'h204, 8'(i));
      rate_chk();
    end
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### irq_flag_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module irq_flag_monitor
  import irq_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        timer_overflow_in,
  input wire logic        ext_irq_pin_in,
  input wire logic [3:0]  upper_port_pins_in,
  input wire logic        irq_req_out,
  input wire logic [3:0]  timer_div_log2_out,
  input wire logic [2:0]  wdt_div_log2_out
);
  logic [7:0] ctrl_r, ctrl_nxt, opt_r, opt_nxt;
  logic [1:0] up_r, up_nxt;
  logic       wr;
  assign wr = psel_in & penable_in & pready_out & pwrite_in;
  // pin flags are not shadowed: their sync delay is not visible here
  always_comb begin
    ctrl_nxt = ctrl_r;
    opt_nxt = opt_r;
    up_nxt = up_r + {1'b0, ~&up_r};
    if (wr && (paddr_in & 12'hdff) == 12'h02c)
      ctrl_nxt = pwdata_in[7:0] & 8'hbf;
    if (wr && paddr_in == 12'h204)
      opt_nxt = pwdata_in[7:0];
    ctrl_nxt[2] = ctrl_nxt[2] | timer_overflow_in;
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= CTRL_RESET;
      opt_r <= OPTION_RESET;
      up_r <= 2'd0;
    end else begin
      ctrl_r <= ctrl_nxt;
      opt_r <= opt_nxt;
      up_r <= up_nxt;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_ctrl_rd;
    pready_out && !pwrite_in && (paddr_in & 12'hdff) == 12'h02c;
  endsequence
  sequence s_settled;
    up_r == 2'd3;
  endsequence
  AST_CTRL_READ: assert property (s_ctrl_rd |->
    prdata_out[31:2] == {24'h00_0000, $past(ctrl_r[7:2])})
    else $error("control read value wrong");
  AST_GIE_BLOCKS: assert property ((!ctrl_r[7])[*2] |-> !irq_req_out)
    else $error("request without global enable");
  AST_NO_SOURCE: assert property ((ctrl_r[5:3] == 3'd0)[*2] |-> !irq_req_out)
    else $error("request without source enable");
  AST_TMR_IRQ: assert property (timer_overflow_in && ctrl_r[7] && ctrl_r[5]
    && !wr |=> ##1 irq_req_out)
    else $error("timer overflow gave no request");
  AST_PORT_IRQ: assert property ($changed(upper_port_pins_in) && ctrl_r[7]
    && ctrl_r[3] |-> ##[1:8] irq_req_out)
    else $error("port change gave no request");
  AST_EXT_IRQ: assert property ((opt_r[6] ? $rose(ext_irq_pin_in)
    : $fell(ext_irq_pin_in)) && ctrl_r[7] && ctrl_r[4] |-> ##[1:8] irq_req_out)
    else $error("pin edge gave no request");
  AST_TMR_RATE: assert property (s_settled ##0 !$past(opt_r[3]) |->
    timer_div_log2_out == {1'b0, $past(opt_r[2:0])} + 4'd1
    && wdt_div_log2_out == 3'd0)
    else $error("timer rate decode wrong");
  AST_PSA_UNDIV: assert property (s_settled ##0 $past(opt_r[3]) |->
    timer_div_log2_out == 4'd0 && wdt_div_log2_out == $past(opt_r[2:0]))
    else $error("watchdog rate decode wrong");
endmodule
bind interrupt_enable_flag_control irq_flag_monitor i_irq_flag_monitor (
  .clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
  .prdata_out, .pready_out, .pslverr_out, .timer_overflow_in, .ext_irq_pin_in,
  .upper_port_pins_in, .irq_req_out, .timer_div_log2_out, .wdt_div_log2_out);
`default_nettype wire

// ### irq_pkg.sv
// What this block does
// - flags set on their event whatever the enables or global enable hold
// - global enable, bit 7, passes unmasked sources when one, blocks all when zero
// - timer overflow enable, bit 5, permits or suppresses the timer interrupt
// - port-change enable, bit 3, permits or suppresses the port-change interrupt
// - timer overflow flag, bit 2, sets on overflow; only software clears it
// - external pin flag, bit 1, sets on pin event, held; enable is bit 4
// - port-change flag, bit 0, sets when any upper port pin changes
// - control register answers at two addresses, one per bank, same storage
// - rate field: timer divides by 2^(field+1), watchdog by 2^field
// - edge select picks rising (one) or falling (zero) pin edge
// - prescaler given to watchdog leaves the timer undivided, 1:1
package irq_pkg;
  localparam int          ADDR_W            = 12;
  localparam int          DATA_W            = 32;
  localparam int          REG_W             = 8;
  // printed register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CTRL_BANK0    = 8'h0b;
  localparam logic [7:0]  IDX_CTRL_BANK1    = 8'h8b;
  localparam logic [7:0]  IDX_OPTION        = 8'h81;
  // interrupt_control fields
  localparam int          BIT_GIE           = 7;
  localparam int          BIT_RSVD          = 6;
  localparam int          BIT_TMR_IE        = 5;
  localparam int          BIT_EXT_IE        = 4;
  localparam int          BIT_PORT_IE       = 3;
  localparam int          BIT_TMR_IF        = 2;
  localparam int          BIT_EXT_IF        = 1;
  localparam int          BIT_PORT_IF       = 0;
  localparam logic [7:0]  CTRL_RESET        = 8'h00;
  // option fields
  localparam int          BIT_EDGE_SEL      = 6;
  localparam int          BIT_PSA           = 3;
  localparam int          RATE_LSB          = 0;
  localparam int          RATE_W            = 3;
  localparam logic [7:0]  OPTION_RESET      = 8'hff;
  localparam int          PORT_PINS         = 4;

  typedef enum logic [1:0] {
    APB_IDLE   = 2'b01,
    APB_ACCESS = 2'b10
  } apb_state_t;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction
endpackage

// ### irq_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module irq_src_model (
  input  wire logic       clk_in,
  input  wire logic       ovf_req_in,
  input  wire logic       pin_req_in,
  input  wire logic [3:0] port_req_in,
  output logic            ovf_out,
  output logic            pin_out,
  output logic [3:0]      port_out
);
  // a counter wrap lasts one clock; a held request repeats it every other clock
  always_ff @(posedge clk_in) begin
    ovf_out <= ovf_req_in & ~ovf_out;
    pin_out <= pin_req_in;
    port_out <= port_req_in;
  end
endmodule
`default_nettype wire

// ### pin_event_detect.sv
`timescale 1ns/10ps
`default_nettype none
module pin_event_detect
  import irq_pkg::*;
#(
  parameter int PINS = PORT_PINS
) (
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire logic            ext_irq_pin_in,
  input  wire logic [PINS-1:0] upper_port_pins_in,
  pin_event_if.src             evt
);
  // stage 1 is the metastable catcher; only stage 2 reads it
  logic [PINS:0] sync1_r, sync1_nxt;
  logic [PINS:0] sync2_r, sync2_nxt;
  logic [PINS:0] prev_r,  prev_nxt;
  logic          rise_r,  rise_nxt;
  logic          fall_r,  fall_nxt;
  logic          chg_r,   chg_nxt;

  always_comb begin
    sync1_nxt = {ext_irq_pin_in, upper_port_pins_in};
    sync2_nxt = sync1_r;
    prev_nxt  = sync2_r;
    rise_nxt  = sync2_r[PINS] & ~prev_r[PINS];
    fall_nxt  = ~sync2_r[PINS] & prev_r[PINS];
    chg_nxt   = |(sync2_r[PINS-1:0] ^ prev_r[PINS-1:0]);
  end

  // pins reset low-level; a pin held high at reset release shows one edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
      rise_r  <= 1'b0;
      fall_r  <= 1'b0;
      chg_r   <= 1'b0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r  <= prev_nxt;
      rise_r  <= rise_nxt;
      fall_r  <= fall_nxt;
      chg_r   <= chg_nxt;
    end
  end

  assign evt.ext_rise    = rise_r;
  assign evt.ext_fall    = fall_r;
  assign evt.port_change = chg_r;
endmodule
`default_nettype wire

// ### pin_event_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pin_event_if;
  logic ext_rise;
  logic ext_fall;
  logic port_change;
  modport src (output ext_rise, output ext_fall, output port_change);
  modport dst (input ext_rise, input ext_fall, input port_change);
endinterface
`default_nettype wire

// ### prescale_decode.sv
`timescale 1ns/10ps
`default_nettype none
module prescale_decode
  import irq_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic [RATE_W-1:0] rate_in,
  input  wire logic              assign_wdt_in,
  output logic       [RATE_W:0]  timer_div_log2_out,
  output logic     [RATE_W-1:0]  wdt_div_log2_out
);
  logic [RATE_W:0]   tdiv_r, tdiv_nxt;
  logic [RATE_W-1:0] wdiv_r, wdiv_nxt;

  always_comb begin
    if (assign_wdt_in) begin
      tdiv_nxt = '0;
      wdiv_nxt = rate_in;
    end else begin
      tdiv_nxt = {1'b0, rate_in} + (RATE_W+1)'(1);
      wdiv_nxt = '0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tdiv_r <= '0;
      wdiv_r <= '0;
    end else begin
      tdiv_r <= tdiv_nxt;
      wdiv_r <= wdiv_nxt;
    end
  end

  assign timer_div_log2_out = tdiv_r;
  assign wdt_div_log2_out   = wdiv_r;
endmodule
`default_nettype wire
